// file: pkg/msm_pkg.sv
// Shared constants, encodings and carrier types of the motor stop control
package msm_pkg;

  // Sequence input terminals and default assignment of the limit functions
  localparam int unsigned TERM_W       = 8;
  localparam int unsigned TSEL_W       = 3;
  localparam logic [2:0]  FWD_TERM_RST = 3'h4;
  localparam logic [2:0]  REV_TERM_RST = 3'h5;

  // Overtravel stop selector values
  localparam logic        OT_TORQUE    = 1'h0;
  localparam logic        OT_BRAKE     = 1'h1;
  localparam logic        OT_SEL_RST   = OT_TORQUE;

  // Stop method setting values
  typedef enum logic [1:0] {
    STOP_BRAKE_HOLD    = 2'h0,
    STOP_BRAKE_RELEASE = 2'h1,
    STOP_COAST_FREE    = 2'h2,
    STOP_COAST_HOLD    = 2'h3
  } msm_stop_t;

  localparam msm_stop_t   STOP_SEL_RST = STOP_BRAKE_HOLD;

  // Accepted configuration
  typedef struct packed {
    logic              ot_sel;
    msm_stop_t         stop_sel;
    logic [TSEL_W-1:0] fwd_term;
    logic [TSEL_W-1:0] rev_term;
  } msm_cfg_t;

  localparam msm_cfg_t CFG_RST = '{
    ot_sel:   OT_SEL_RST,
    stop_sel: STOP_SEL_RST,
    fwd_term: FWD_TERM_RST,
    rev_term: REV_TERM_RST
  };

  // Drive and brake status bundle
  typedef struct packed {
    logic fwd_limit;
    logic rev_limit;
    logic servo_en;
    logic torque_clamp;
    logic brake_release;
    logic fwd_allow;
    logic rev_allow;
    logic stopping;
  } msm_stat_t;

  localparam msm_stat_t STAT_RST = '0;

  // Stop sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_OPEN,
    ST_RUN,
    ST_OT_TORQ,
    ST_DB_STOP,
    ST_COAST
  } msm_state_t;

endpackage : msm_pkg

// file: rtl/msm_stop_ctrl.sv
// Motor stop sequencer: alarm and overtravel stop, brake and coast handling
// Notes on behaviour
// - Stop motor on servo alarm or overtravel
// - Forward limit stops forward, reverse limit reverse
// - Limit inputs mapped to terminals, defaults fixed
// - Limit shows status only, raises no alarm
// - Overtravel selector: 0 torque stop, 1 brake
// - Overtravel selector resets 0, loads when servo off
// - Torque stop on overtravel clamps motor torque
// - Brake switch closed whenever drive is unpowered
// - Powered brake switch follows stop method setting
// - Never brake while servo torque control active
// - Method: hold, release, coast, coast then brake
// - Stop method resets 0, loads when servo off
// - Brake stop shorts winding while still turning
// - Free-run stop: no torque, no brake
`timescale 1ns/100ps
module msm_stop_ctrl
  import msm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              clk_en_i,
  // Sequence input terminals from the sensors
  input  wire logic [TERM_W-1:0] terminals_i,
  // Drive state from the control loops
  input  wire logic              servo_alarm_i,
  input  wire logic              servo_on_i,
  input  wire logic              standstill_i,
  input  wire logic              fwd_cmd_i,
  input  wire logic              rev_cmd_i,
  // Configuration
  input  wire msm_cfg_t          cfg_i,
  input  wire logic              cfg_load_i,
  output      msm_cfg_t          cfg_o,
  // Status and drive outputs
  output      msm_stat_t         stat_o
);

  typedef struct packed {
    msm_state_t state;
    msm_cfg_t   cfg;
    msm_stat_t  stat;
  } msm_reg_t;

  msm_reg_t            q;
  msm_reg_t            d;
  logic [TERM_W-1:0]   term_sync;
  logic                fwd_lim;
  logic                rev_lim;
  logic                into_lim;
  logic                any_lim;

  // Limit terminals enter through the synchroniser
  msm_term_sync u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .term_i    (terminals_i),
    .term_o    (term_sync)
  );

  // Assignable limit inputs picked from the synchronised terminals
  assign fwd_lim  = term_sync[q.cfg.fwd_term];
  assign rev_lim  = term_sync[q.cfg.rev_term];
  assign any_lim  = fwd_lim | rev_lim;
  // Only motion toward an active limit counts as overtravel
  assign into_lim = (fwd_lim & fwd_cmd_i) | (rev_lim & rev_cmd_i);

  // State entered when a stop begins, by stop method
  function automatic msm_state_t stop_entry(input msm_stop_t sel);
    msm_state_t s;
    if (sel == STOP_BRAKE_HOLD || sel == STOP_BRAKE_RELEASE)
      s = ST_DB_STOP;
    else
      s = ST_COAST;
    return s;
  endfunction : stop_entry

  // State kept after standstill, by stop method
  function automatic msm_state_t rest_state(input msm_stop_t sel);
    msm_state_t s;
    if (sel == STOP_BRAKE_HOLD || sel == STOP_COAST_HOLD)
      s = ST_HOLD;
    else
      s = ST_OPEN;
    return s;
  endfunction : rest_state

  // Next state, configuration and outputs
  always_comb
  begin
    d = q;
    // Settings change only at rest with the servo off, so a stop in progress keeps its method
    if (cfg_load_i && !q.stat.servo_en && !q.stat.stopping)
      d.cfg = cfg_i;
    unique case (q.state)
      ST_RUN, ST_OT_TORQ:
      begin
        if (servo_alarm_i || !servo_on_i)
          d.state = stop_entry(q.cfg.stop_sel);
        else if (into_lim && q.cfg.ot_sel == OT_BRAKE)
          d.state = stop_entry(q.cfg.stop_sel);
        else if (q.cfg.ot_sel == OT_TORQUE && (into_lim || (q.state == ST_OT_TORQ && any_lim)))
          d.state = ST_OT_TORQ;
        else
          d.state = ST_RUN;
      end
      ST_DB_STOP, ST_COAST:
      begin
        if (standstill_i)
          d.state = rest_state(q.cfg.stop_sel);
      end
      ST_HOLD, ST_OPEN:
      begin
        if (servo_on_i && !servo_alarm_i && !into_lim)
          d.state = ST_RUN;
      end
    endcase
    // Outputs registered from the next state and the mapped limit inputs
    d.stat.servo_en      = (d.state == ST_RUN) || (d.state == ST_OT_TORQ);
    d.stat.torque_clamp  = (d.state == ST_OT_TORQ);
    // Brake closes only in servo-off states that call for it
    d.stat.brake_release = !((d.state == ST_DB_STOP) || (d.state == ST_HOLD));
    d.stat.stopping      = (d.state == ST_DB_STOP) || (d.state == ST_COAST);
    d.stat.fwd_limit     = fwd_lim;
    d.stat.rev_limit     = rev_lim;
    d.stat.fwd_allow     = d.stat.servo_en && !fwd_lim;
    d.stat.rev_allow     = d.stat.servo_en && !rev_lim;
  end

  // State register; reset leaves the winding shorted, as when unpowered
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q.state <= ST_HOLD;
      q.cfg   <= CFG_RST;
      q.stat  <= STAT_RST;
    end
    else if (clk_en_i)
      q <= d;
  end

  assign cfg_o  = q.cfg;
  assign stat_o = q.stat;

  // Checks on the sequencer
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_alarm_halt;
    (clk_en_i && servo_alarm_i && q.stat.servo_en) |=> (!stat_o.servo_en && stat_o.stopping);
  endproperty
  a_alarm_halt: assert property (p_alarm_halt) else $error("alarm did not stop the drive");

  property p_fwd_block;
    stat_o.fwd_limit |-> !stat_o.fwd_allow;
  endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("forward allowed at forward limit");

  property p_term_map;
    (clk_en_i && !cfg_load_i && $stable(terminals_i))[*4] |->
      (stat_o.fwd_limit == terminals_i[q.cfg.fwd_term]) && (stat_o.rev_limit == terminals_i[q.cfg.rev_term]);
  endproperty
  a_term_map: assert property (p_term_map) else $error("limit indication not from mapped terminal");

  property p_lim_no_stop;
    (clk_en_i && q.state == ST_RUN && servo_on_i && !servo_alarm_i && !fwd_cmd_i && !rev_cmd_i)
      |=> stat_o.servo_en;
  endproperty
  a_lim_no_stop: assert property (p_lim_no_stop) else $error("idle limit stopped the drive");

  property p_ot_brake;
    (clk_en_i && q.stat.servo_en && into_lim && q.cfg.ot_sel == OT_BRAKE) |=> !stat_o.servo_en;
  endproperty
  a_ot_brake: assert property (p_ot_brake) else $error("brake overtravel kept servo on");

  property p_ot_torque;
    (clk_en_i && q.stat.servo_en && into_lim && servo_on_i && !servo_alarm_i && q.cfg.ot_sel == OT_TORQUE)
      |=> (stat_o.servo_en && stat_o.torque_clamp);
  endproperty
  a_ot_torque: assert property (p_ot_torque) else $error("torque overtravel not clamped");

  property p_cfg_lock;
    (q.stat.servo_en || q.stat.stopping) |=> $stable(cfg_o);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("setting changed with servo on");

  property p_no_brake_on;
    !(stat_o.servo_en && !stat_o.brake_release);
  endproperty
  a_no_brake_on: assert property (p_no_brake_on) else $error("brake closed while servo on");

  property p_db_decel;
    (stat_o.stopping && q.cfg.stop_sel inside {STOP_BRAKE_HOLD, STOP_BRAKE_RELEASE}) |-> !stat_o.brake_release;
  endproperty
  a_db_decel: assert property (p_db_decel) else $error("brake stop without brake");

  property p_free_run;
    (stat_o.stopping && q.cfg.stop_sel inside {STOP_COAST_FREE, STOP_COAST_HOLD})
      |-> (stat_o.brake_release && !stat_o.servo_en);
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run applied torque or brake");

  property p_rest;
    (clk_en_i && stat_o.stopping && standstill_i)
      |=> (stat_o.brake_release == ($past(q.cfg.stop_sel) inside {STOP_BRAKE_RELEASE, STOP_COAST_FREE}));
  endproperty
  a_rest: assert property (p_rest) else $error("wrong brake state after standstill");

  property p_move_away;
    (stat_o.servo_en && stat_o.fwd_limit && !stat_o.rev_limit) |-> stat_o.rev_allow;
  endproperty
  a_move_away: assert property (p_move_away) else $error("move away from limit blocked");

  // Limit and direction checks
  property p_rev_block;
    stat_o.rev_limit |-> !stat_o.rev_allow;
  endproperty
  a_rev_block: assert property (p_rev_block) else $error("reverse allowed at reverse limit");

  property p_move_away_rev;
    (stat_o.servo_en && stat_o.rev_limit && !stat_o.fwd_limit) |-> stat_o.fwd_allow;
  endproperty
  a_move_away_rev: assert property (p_move_away_rev) else $error("move away from reverse limit blocked");

  property p_start_blocked;
    (clk_en_i && !q.stat.servo_en && !q.stat.stopping && into_lim) |=> !stat_o.servo_en;
  endproperty
  a_start_blocked: assert property (p_start_blocked) else $error("started toward an active limit");

  // Torque clamp checks
  property p_clamp_servo;
    stat_o.torque_clamp |-> (stat_o.servo_en && stat_o.brake_release);
  endproperty
  a_clamp_servo: assert property (p_clamp_servo) else $error("clamp without torque control");

  property p_ot_release;
    (clk_en_i && q.state == ST_OT_TORQ && servo_on_i && !servo_alarm_i && !any_lim)
      |=> (stat_o.servo_en && !stat_o.torque_clamp);
  endproperty
  a_ot_release: assert property (p_ot_release) else $error("clamp kept after limit cleared");

  // Stop sequence checks
  property p_alarm_no_start;
    (clk_en_i && !q.stat.servo_en && !q.stat.stopping && servo_alarm_i) |=> !stat_o.servo_en;
  endproperty
  a_alarm_no_start: assert property (p_alarm_no_start) else $error("servo started under alarm");

  property p_db_entry;
    (clk_en_i && q.stat.servo_en && servo_alarm_i && q.cfg.stop_sel inside {STOP_BRAKE_HOLD, STOP_BRAKE_RELEASE})
      |=> (stat_o.stopping && !stat_o.brake_release);
  endproperty
  a_db_entry: assert property (p_db_entry) else $error("brake stop did not close brake");

  property p_coast_entry;
    (clk_en_i && q.stat.servo_en && servo_alarm_i && q.cfg.stop_sel inside {STOP_COAST_FREE, STOP_COAST_HOLD})
      |=> (stat_o.stopping && stat_o.brake_release && !stat_o.servo_en);
  endproperty
  a_coast_entry: assert property (p_coast_entry) else $error("free run stop not entered");

  property p_stop_wait;
    (clk_en_i && q.stat.stopping && !standstill_i) |=> stat_o.stopping;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("stop ended before standstill");

  property p_rest_off;
    (clk_en_i && !q.stat.servo_en && !q.stat.stopping && !servo_on_i) |=> (!stat_o.servo_en && !stat_o.stopping);
  endproperty
  a_rest_off: assert property (p_rest_off) else $error("rest state left without servo on");

  property p_hold_closed;
    (q.state == ST_HOLD) |-> !stat_o.brake_release;
  endproperty
  a_hold_closed: assert property (p_hold_closed) else $error("brake open in hold state");

  // Configuration and clock enable checks
  property p_cfg_take;
    (clk_en_i && cfg_load_i && !q.stat.servo_en && !q.stat.stopping) |=> (cfg_o == $past(cfg_i));
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("setting not taken at rest");

  property p_freeze;
    !clk_en_i |=> $stable(q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  c_alarm_stop: cover property (q.state == ST_RUN ##1 q.state == ST_DB_STOP ##[1:20] q.state == ST_HOLD);
  c_ot_torque:  cover property (q.state == ST_OT_TORQ ##[1:20] q.state == ST_RUN);
  c_coast_open: cover property (q.state == ST_COAST ##[1:20] q.state == ST_OPEN);
  c_ot_coast:   cover property (q.state == ST_RUN ##1 q.state == ST_COAST);
  c_move_away:  cover property (stat_o.servo_en && stat_o.rev_limit && stat_o.fwd_allow);

endmodule : msm_stop_ctrl

// file: rtl/msm_term_sync.sv
// Two-stage synchroniser for the sequence input terminals
`timescale 1ns/100ps
module msm_term_sync
  import msm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              clk_en_i,
  // Terminals
  input  wire logic [TERM_W-1:0] term_i,
  output      logic [TERM_W-1:0] term_o
);

  typedef struct packed {
    logic [TERM_W-1:0] meta;
    logic [TERM_W-1:0] sync;
  } msm_sync_reg_t;

  msm_sync_reg_t q;
  msm_sync_reg_t d;

  // Per-terminal two flip-flop chain; first stage feeds only the second
  always_comb
  begin
    d = q;
    for (int i = 0; i < TERM_W; i++)
    begin
      d.meta[i] = term_i[i];
      d.sync[i] = q.meta[i];
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      q <= '0;
    else if (clk_en_i)
      q <= d;
  end

  assign term_o = q.sync;

endmodule : msm_term_sync

// file: tb/msm_sensor_model.sv
// Limit sensor model wired onto the sequence input terminals
`timescale 1ns/100ps
module msm_sensor_model
  import msm_pkg::*;
#(
  parameter int unsigned FWD_POS = 4,
  parameter int unsigned REV_POS = 5
)
(
  // Sensor hits
  input  wire logic              fwd_hit_i,
  input  wire logic              rev_hit_i,
  // Terminals
  output      logic [TERM_W-1:0] terminals_o
);
  // Each sensor drives its default terminal, the rest stay inactive
  always_comb
  begin
    terminals_o          = '0;
    terminals_o[FWD_POS] = fwd_hit_i;
    terminals_o[REV_POS] = rev_hit_i;
  end
endmodule : msm_sensor_model

// file: tb/tb_msm_stop_ctrl.sv
// Self-checking bench of the motor stop sequencer
`timescale 1ns/100ps
module tb_msm_stop_ctrl
  import msm_pkg::*;
;
  logic              clk_i, reset_n_i;
  logic              alarm, son, still, fcmd, rcmd, fhit, rhit, ld, en;
  logic [TERM_W-1:0] term;
  msm_cfg_t          cfg_i, cfg_o, cfg_x;
  msm_stat_t         stat_o;
  int                error_cnt, num_checks, cyc, k;

  // Sensors on the far side
  msm_sensor_model sens (.fwd_hit_i(fhit), .rev_hit_i(rhit), .terminals_o(term));

  msm_stop_ctrl dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en), .terminals_i(term),
    .servo_alarm_i(alarm), .servo_on_i(son), .standstill_i(still), .fwd_cmd_i(fcmd),
    .rev_cmd_i(rcmd), .cfg_i(cfg_i), .cfg_load_i(ld), .cfg_o(cfg_o), .stat_o(stat_o));

  // Clock generation
  initial
  begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task chk_stat(input msm_stat_t e);
    num_checks++;
    if (stat_o !== e)
    begin
      error_cnt++;
      $display("ERROR stat_o expected %h seen %h", e, stat_o);
    end
  endtask : chk_stat

  task chk_cfg(input msm_cfg_t e);
    num_checks++;
    if (cfg_o !== e)
    begin
      error_cnt++;
      $display("ERROR cfg_o expected %h seen %h", e, cfg_o);
    end
  endtask : chk_cfg

  // Loads settings with a one-cycle strobe, starting at an edge
  task load(input logic ot, input logic [1:0] sel, input logic [TSEL_W-1:0] ft, input logic [TSEL_W-1:0] rt);
    @(posedge clk_i);
    cfg_x = '{ot_sel: ot, stop_sel: msm_stop_t'(sel), fwd_term: ft, rev_term: rt};
    cfg_i <= cfg_x;
    ld    <= 1'h1;
    @(posedge clk_i);
    ld    <= 1'h0;
    step(1);
  endtask : load

  // Cycle ceiling against hangs
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      summarize();
    end
  end

  initial
  begin
    {alarm, son, still, fcmd, rcmd, fhit, rhit, ld} = '0;
    en = 1'h1;
    cfg_i = CFG_RST;
    reset_n_i = 1'h0;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    step(2);
    chk_cfg(CFG_RST);
    chk_stat(STAT_RST);
    @(posedge clk_i);
    reset_n_i <= 1'h1;
    // Alarm stop for every stop method
    for (k = 0; k < 4; k++)
    begin
      load(1'h0, k[1:0], FWD_TERM_RST, REV_TERM_RST);
      chk_cfg(cfg_x);
      @(posedge clk_i);
      son   <= 1'h1;
      still <= 1'h0;
      step(1);
      chk_stat(8'h2E);
      @(posedge clk_i);
      alarm <= 1'h1;
      son   <= 1'h0;
      step(1);
      chk_stat((k < 2) ? 8'h01 : 8'h09);
      @(posedge clk_i);
      alarm <= 1'h0;
      still <= 1'h1;
      step(1);
      chk_stat((k == 1 || k == 2) ? 8'h08 : 8'h00);
    end
    $display("alarm stop test done");
    // Torque-controlled overtravel stop on the forward limit
    load(1'h0, 2'h0, FWD_TERM_RST, REV_TERM_RST);
    @(posedge clk_i);
    son   <= 1'h1;
    still <= 1'h0;
    fhit  <= 1'h1;
    fcmd  <= 1'h1;
    step(6);
    chk_stat(8'hBA);
    load(1'h1, 2'h3, FWD_TERM_RST, REV_TERM_RST);
    chk_cfg('{ot_sel: 1'h0, stop_sel: STOP_BRAKE_HOLD, fwd_term: 3'h4, rev_term: 3'h5});
    @(posedge clk_i);
    fhit <= 1'h0;
    step(6);
    chk_stat(8'h2E);
    @(posedge clk_i);
    son   <= 1'h0;
    fcmd  <= 1'h0;
    still <= 1'h1;
    step(3);
    chk_stat(8'h00);
    $display("torque overtravel test done");
    // Brake overtravel stop on the reverse limit, coast then release
    load(1'h1, 2'h2, FWD_TERM_RST, REV_TERM_RST);
    @(posedge clk_i);
    son   <= 1'h1;
    still <= 1'h0;
    step(1);
    chk_stat(8'h2E);
    @(posedge clk_i);
    rhit <= 1'h1;
    rcmd <= 1'h1;
    step(6);
    chk_stat(8'h49);
    @(posedge clk_i);
    still <= 1'h1;
    step(3);
    chk_stat(8'h48);
    @(posedge clk_i);
    rcmd <= 1'h0;
    fcmd <= 1'h1;
    step(1);
    chk_stat(8'h6C);
    $display("brake overtravel test done");
    // Clock enable low freezes the sequencer, then the limits are remapped
    @(posedge clk_i);
    en  <= 1'h0;
    son <= 1'h0;
    step(3);
    chk_stat(8'h6C);
    @(posedge clk_i);
    en <= 1'h1;
    step(1);
    chk_stat(8'h49);
    load(1'h1, 2'h2, 3'h5, 3'h4);
    chk_cfg(cfg_x);
    chk_stat(8'h88);
    $display("clock enable and remap test done");
    summarize();
  end
endmodule : tb_msm_stop_ctrl
